/* File: src/hb_ctrl_pkg.sv */
// Constants and types for the half-bridge soft-start and burst sequencer
package hb_ctrl_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ          = 10000;
    localparam int T_SS1_US         = 624;
    localparam int T_SS2_US         = 2500;
    localparam int T_SS3_US         = 3750;
    localparam int T_BM_ENTRY_MS    = 10;
    localparam int T_BURST_ON_MS    = 10;
    localparam int T_OVERCURRENT_LEVEL_ONE_MS        = 50;
    localparam int T_SLEEP_WIN_US   = 400;
    localparam int T_DT_MIN_NS      = 250;
    localparam int T_DT_MAX_NS      = 750;
    localparam int SS1_CYC      = T_SS1_US * CLK_KHZ / 1000;
    localparam int SS2_CYC      = T_SS2_US * CLK_KHZ / 1000;
    localparam int SS3_CYC      = T_SS3_US * CLK_KHZ / 1000;
    localparam int BM_ENTRY_CYC = T_BM_ENTRY_MS * CLK_KHZ;
    localparam int BURST_ON_CYC = T_BURST_ON_MS * CLK_KHZ;
    localparam int OVERCURRENT_LEVEL_ONE_CYC     = T_OVERCURRENT_LEVEL_ONE_MS * CLK_KHZ;
    localparam int SLEEP_WIN_CYC = T_SLEEP_WIN_US * CLK_KHZ / 1000;
    localparam int DT_MIN_CYC = (T_DT_MIN_NS * CLK_KHZ + 999999) / 1000000;
    localparam int DT_MAX_CYC = T_DT_MAX_NS * CLK_KHZ / 1000000;

    // ------------------------------------------------------------
    // Levels and frequencies
    // ------------------------------------------------------------
    localparam logic [11:0] BM_ENTRY_MV  = 12'h2EE;  // 750 mV
    localparam logic [11:0] BM_MAX_MV    = 12'h8CA;  // 2250 mV
    localparam logic [11:0] BM_WARN_MV   = 12'h7D0;  // 2000 mV
    localparam logic [11:0] BM_STEP_MV   = 12'h064;  // 100 mV
    localparam int          BM_RAMP_MV   = 1500;
    localparam logic [15:0] SS_START_MAX = 16'h0514; // 1300 kHz
    localparam int          CCO_NUM      = 2;        // 400 kHz/mA = 2/5
    localparam int          CCO_DEN      = 5;
    localparam logic [15:0] OCP_STEP_KHZ = 16'h0005;
    localparam int          SOFT_STEP_CYC = 10;      // 1 kHz per us
    localparam int          PL_HIST      = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_SS1       = 4'h1,
        ST_SS2       = 4'h2,
        ST_SS3       = 4'h3,
        ST_NORMAL    = 4'h4,
        ST_SOFT_OFF  = 4'h5,
        ST_SLEEP     = 4'h6,
        ST_BURST_ON  = 4'h7,
        ST_PWR_LIMIT = 4'h8,
        ST_FAULT     = 4'h9
    } mode_t;

    typedef struct packed {
        logic        bus_sense_input_ok;
        logic        burst_current_zero;
        logic        low_side_current_sense_above_ocp;
        logic        low_side_current_sense_below_neg;
        logic        high_side_gate;
        logic        low_side_gate;
        logic [11:0] burst_control_mv;
        logic [11:0] frequency_set_node_ua;
    } sense_t;

    typedef struct packed {
        logic [15:0] fmin;
        logic [15:0] fmax;
        logic [15:0] power_limit_frequency;
    } freq_cfg_t;

    typedef struct packed {
        logic [15:0] freq_target;
        logic [11:0] bm_clamp_mv;
        logic        bm_clamp_en;
        logic        stage_run;
        logic        burst_active;
        logic        restart_req;
        logic [3:0]  dead_time;
    } cmd_t;

endpackage

/* File: src/dead_time_meter.sv */
// Self-adaptive dead time measurement
`timescale 1ns/1ps
`default_nettype none
module dead_time_meter (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       high_side_gate,
    input  wire logic       low_side_current_sense_below_neg,
    output logic      [3:0] dead_time
);
    import hb_ctrl_pkg::*;

    typedef struct packed {
        logic       hs_prev;
        logic       busy;
        logic [3:0] cnt;
        logic [3:0] dt;
    } dt_state_t;

    dt_state_t s;
    dt_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.hs_prev = high_side_gate;
        if (s.hs_prev && !high_side_gate) begin
            next_s.busy = 1'b1;
            next_s.cnt  = 4'h0;
        end else if (s.busy) begin
            next_s.cnt = s.cnt + 4'h1;
            // Clamped so a missing sense edge cannot stretch dead time
            if (low_side_current_sense_below_neg || s.cnt >= 4'(DT_MAX_CYC)) begin
                next_s.busy = 1'b0;
                if (s.cnt < 4'(DT_MIN_CYC))
                    next_s.dt = 4'(DT_MIN_CYC);
                else if (s.cnt > 4'(DT_MAX_CYC))
                    next_s.dt = 4'(DT_MAX_CYC);
                else
                    next_s.dt = s.cnt;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            s <= '{hs_prev: 1'b0, busy: 1'b0, cnt: 4'h0, dt: 4'(DT_MAX_CYC)};
        else
            s <= next_s;
    end

    assign dead_time = s.dt;
endmodule
`default_nettype wire

/* File: src/halfbridge_softstart_burst_ctrl.sv */
// Half-bridge soft-start, burst mode and over-current foldback sequencer
`timescale 1ns/1ps
`default_nettype none
module halfbridge_softstart_burst_ctrl #(
    parameter int P_SS1_CYC      = hb_ctrl_pkg::SS1_CYC,
    parameter int P_SS2_CYC      = hb_ctrl_pkg::SS2_CYC,
    parameter int P_SS3_CYC      = hb_ctrl_pkg::SS3_CYC,
    parameter int P_BM_ENTRY_CYC = hb_ctrl_pkg::BM_ENTRY_CYC,
    parameter int P_BURST_ON_CYC = hb_ctrl_pkg::BURST_ON_CYC,
    parameter int P_OVERCURRENT_LEVEL_ONE_CYC     = hb_ctrl_pkg::OVERCURRENT_LEVEL_ONE_CYC
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire hb_ctrl_pkg::sense_t    sense,
    input  wire hb_ctrl_pkg::freq_cfg_t cfg,
    output hb_ctrl_pkg::cmd_t       cmd
);
    import hb_ctrl_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mode_t                      mode;
        logic [15:0]                freq;
        logic [23:0]                acc;
        logic [19:0]                t;
        logic [4:0]                 pre;
        logic [19:0]                on_time;
        logic [19:0]                off_time;
        logic [19:0]                oc_time;
        logic [15:0]                ocp_off;
        logic                       oc_seen;
        logic                       lsg_prev;
        logic                       armed;
        logic [12:0]                win;
        logic [3:0]                 hist_n;
        logic [PL_HIST-1:0][11:0]   hist;
        cmd_t                       cmd;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;
    logic [3:0]  dt_meas;

    dead_time_meter u_dt (
        .clk            (clk),
        .rst_n          (rst_n),
        .high_side_gate (sense.high_side_gate),
        .low_side_current_sense_below_neg (sense.low_side_current_sense_below_neg),
        .dead_time      (dt_meas)
    );

    // ------------------------------------------------------------
    // Derived frequencies
    // ------------------------------------------------------------
    logic [23:0] span;
    logic [23:0] f_ss0_raw;
    logic [15:0] f_ss0;
    logic [15:0] f_ss1;
    logic [15:0] f_burst;
    logic [15:0] f_cco;
    logic [23:0] cco_prod;

    always_comb begin
        span      = (cfg.fmax > cfg.fmin) ? 24'(cfg.fmax - cfg.fmin) : 24'h0;
        f_ss0_raw = (span << 2) + 24'(cfg.fmin);
        f_ss0     = (f_ss0_raw > 24'(SS_START_MAX)) ? SS_START_MAX
                    : f_ss0_raw[15:0];
        f_ss1     = 16'((span * 24'h00000D) / 24'h000005)
                    + cfg.fmin;
        f_burst   = 16'(((span << 2)) / 24'h000003) + cfg.fmin;
        cco_prod  = 24'(sense.frequency_set_node_ua) * 24'(CCO_NUM);
        f_cco     = 16'(cco_prod / 24'(CCO_DEN));
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic        hb_edge;
    logic        pause;
    logic [23:0] delta;
    logic [23:0] len;
    logic [23:0] acc_sum;
    logic [15:0] fold;
    logic        run;

    always_comb begin
        next_s   = s;
        hb_edge  = sense.low_side_gate && !s.lsg_prev;
        pause    = sense.low_side_current_sense_above_ocp;
        delta    = 24'h0;
        len      = 24'h1;
        acc_sum  = 24'h0;
        fold     = 16'h0;
        run      = 1'b0;
        next_s.lsg_prev = sense.low_side_gate;

        // Over-current foldback, one step per switching cycle
        if (hb_edge) begin
            next_s.oc_seen = 1'b0;
            next_s.ocp_off = s.oc_seen ? s.ocp_off + OCP_STEP_KHZ
                             : 16'h0;
            if (s.ocp_off > cfg.fmax)
                next_s.ocp_off = cfg.fmax;
        end
        // Set after the clear: a hit on the first edge of a cycle counts
        if (sense.low_side_gate && sense.low_side_current_sense_above_ocp)
            next_s.oc_seen = 1'b1;

        case (s.mode)
            ST_SS1: begin
                delta = 24'(f_ss0 - f_ss1);
                len   = 24'(P_SS1_CYC);
            end
            ST_SS2: begin
                delta = (f_ss1 > cfg.fmax) ? 24'(f_ss1 - cfg.fmax) : 24'h0;
                len   = 24'(P_SS2_CYC);
            end
            ST_SS3: begin
                delta = span;
                len   = 24'(P_SS3_CYC);
            end
            default: begin
                delta = 24'h0;
                len   = 24'h1;
            end
        endcase
        acc_sum = s.acc + delta;

        case (s.mode)
            ST_IDLE: begin
                next_s.cmd.stage_run = 1'b0;
                if (sense.bus_sense_input_ok) begin
                    next_s.mode = ST_SS1;
                    next_s.freq = f_ss0;
                    next_s.t    = 20'h0;
                    next_s.acc  = 24'h0;
                    next_s.cmd.stage_run   = 1'b1;
                    next_s.cmd.bm_clamp_en = 1'b1;
                    next_s.cmd.bm_clamp_mv = BM_ENTRY_MV;
                end
            end
            ST_SS1, ST_SS2, ST_SS3: begin
                // Time-driven sweep; a paused cycle does not age the phase
                if (!pause && 24'(s.t) < len) begin
                    next_s.t = s.t + 20'h1;
                    if (acc_sum >= len && s.freq != 16'h0) begin
                        next_s.freq = s.freq - 16'h1;
                        next_s.acc  = acc_sum - len;
                    end else begin
                        next_s.acc = acc_sum;
                    end
                end
                if (s.mode == ST_SS3 && !pause && s.cmd.bm_clamp_mv < BM_MAX_MV) begin
                    next_s.pre = s.pre + 5'h1;
                    if (s.pre >= 5'((P_SS3_CYC / BM_RAMP_MV) - 1)) begin
                        next_s.pre = 5'h0;
                        next_s.cmd.bm_clamp_mv =
                            s.cmd.bm_clamp_mv + 12'h001;
                    end
                end
                if (!pause && 24'(s.t) + 24'h1 >= len && s.mode != ST_SS3) begin
                    next_s.t   = 20'h0;
                    next_s.acc = 24'h0;
                    next_s.pre = 5'h0;
                    if (s.mode == ST_SS1) begin
                        next_s.mode = ST_SS2;
                        next_s.freq = f_ss1;
                    end else begin
                        next_s.mode = ST_SS3;
                        next_s.freq = cfg.fmax;
                    end
                end
                if (s.mode == ST_SS3 && 24'(s.t) >= len)
                    next_s.freq = cfg.fmin;
                if (s.mode == ST_SS3 && sense.burst_current_zero) begin
                    next_s.mode = ST_NORMAL;
                    next_s.cmd.bm_clamp_en = 1'b0;
                    next_s.freq = f_cco;
                    next_s.t = 20'h0;
                end
            end
            ST_NORMAL: begin
                next_s.freq = f_cco;
                // Entry is judged only once the current loop owns frequency
                if (sense.burst_control_mv < BM_ENTRY_MV) begin
                    next_s.t = s.t + 20'h1;
                    if (32'(s.t) + 32'h1 > 32'(P_BM_ENTRY_CYC)) begin
                        next_s.mode = ST_SOFT_OFF;
                        next_s.freq = cfg.fmax;
                        next_s.cmd.burst_active = 1'b1;
                        next_s.pre = 5'h0;
                    end
                end else begin
                    next_s.t = 20'h0;
                end
            end
            ST_SOFT_OFF: begin
                next_s.pre = s.pre + 5'h1;
                if (s.pre >= 5'(SOFT_STEP_CYC - 1)) begin
                    next_s.pre = 5'h0;
                    if (s.freq < f_burst)
                        next_s.freq = s.freq + 16'h1;
                end
                if (s.freq >= f_burst) begin
                    next_s.mode          = ST_SLEEP;
                    next_s.cmd.stage_run = 1'b0;
                    next_s.off_time      = 20'h0;
                    next_s.armed         = 1'b0;
                end
            end
            ST_SLEEP: begin
                if (s.off_time != 20'hFFFFF)
                    next_s.off_time = s.off_time + 20'h1;
                if (sense.burst_control_mv >= BM_WARN_MV) begin
                    next_s.armed = 1'b1;
                    if (!s.armed)
                        next_s.win = 13'h0;
                    else if (s.win != 13'h1FFF)
                        next_s.win = s.win + 13'h1;
                end else begin
                    next_s.armed = 1'b0;
                end
                if (sense.burst_control_mv >= BM_MAX_MV) begin
                    next_s.cmd.stage_run = 1'b1;
                    next_s.on_time = 20'h0;
                    next_s.pre     = 5'h0;
                    // An abrupt jump past both levels counts as fast
                    if (!s.armed || 32'(s.win) < 32'(SLEEP_WIN_CYC)) begin
                        next_s.mode = ST_NORMAL;
                        next_s.cmd.burst_active = 1'b0;
                        next_s.t = 20'h0;
                    end else begin
                        next_s.mode = ST_BURST_ON;
                        next_s.freq = f_burst;
                    end
                end
            end
            ST_BURST_ON, ST_PWR_LIMIT: begin
                if (s.on_time != 20'hFFFFF)
                    next_s.on_time = s.on_time + 20'h1;
                if (s.mode == ST_BURST_ON) begin
                    next_s.pre = s.pre + 5'h1;
                    if (s.pre >= 5'(SOFT_STEP_CYC - 1)) begin
                        next_s.pre = 5'h0;
                        if (s.freq > cfg.power_limit_frequency)
                            next_s.freq = s.freq - 16'h1;
                    end
                    if (s.freq <= cfg.power_limit_frequency) begin
                        next_s.mode   = ST_PWR_LIMIT;
                        next_s.hist_n = 4'h0;
                    end
                end else begin
                    next_s.freq = cfg.power_limit_frequency;
                    if (hb_edge) begin
                        next_s.hist = {s.hist[PL_HIST-2:0],
                                       sense.burst_control_mv};
                        if (s.hist_n < 4'(PL_HIST))
                            next_s.hist_n = s.hist_n + 4'h1;
                    end
                end
                if (sense.burst_current_zero) begin
                    next_s.mode = ST_SOFT_OFF;
                    next_s.pre  = 5'h0;
                end
                if (s.mode == ST_PWR_LIMIT &&
                    ((s.hist_n == 4'(PL_HIST) &&
                      sense.burst_control_mv >=
                      s.hist[PL_HIST-1] + BM_STEP_MV) ||
                     32'(s.on_time) > 32'(P_BURST_ON_CYC) ||
                     {1'b0, s.on_time} > {s.off_time, 1'b0})) begin
                    next_s.mode = ST_NORMAL;
                    next_s.cmd.burst_active = 1'b0;
                    next_s.t = 20'h0;
                end
            end
            ST_FAULT: begin
                next_s.cmd.stage_run   = 1'b0;
                next_s.cmd.restart_req = 1'b1;
            end
            default: begin
                next_s.mode = ST_IDLE;
            end
        endcase

        // Level-one over-current timeout while the stage switches
        run = s.cmd.stage_run && s.mode != ST_FAULT;
        if (run && (s.oc_seen || s.ocp_off != 16'h0)) begin
            next_s.oc_time = s.oc_time + 20'h1;
            if (32'(s.oc_time) + 32'h1 > 32'(P_OVERCURRENT_LEVEL_ONE_CYC)) begin
                next_s.mode = ST_FAULT;
                next_s.cmd.stage_run   = 1'b0;
                next_s.cmd.restart_req = 1'b1;
            end
        end else begin
            next_s.oc_time = 20'h0;
        end

        // Foldback raises the command but never past fmax
        if (next_s.freq >= cfg.fmax || !run)
            fold = next_s.freq;
        else if (32'(next_s.freq) + 32'(next_s.ocp_off) > 32'(cfg.fmax))
            fold = cfg.fmax;
        else
            fold = next_s.freq + next_s.ocp_off;
        next_s.cmd.freq_target = fold;
        next_s.cmd.dead_time   = dt_meas;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign cmd = s.cmd;
endmodule
`default_nettype wire

/* File: sim/hb_stage_model.sv */
// Behavioural power stage: gate phases and negative sense pulse
`timescale 1ns/1ps
`default_nettype none
module hb_stage_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      hs,
    output logic      ls,
    output logic      neg
);
    logic [3:0] ph;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) ph <= 4'h0;
        else ph <= run ? ph + 4'h1 : 4'h0;
    end
    // Gates idle low while stopped, so no stale level is seen
    assign hs  = run && ph < 4'h4;
    assign neg = run && ph == 4'h8;
    assign ls  = run && ph > 4'h8;
endmodule
`default_nettype wire

/* File: sim/halfbridge_softstart_burst_ctrl_assertions.sv */
// Port checks for the half-bridge sequencer
`timescale 1ns/1ps
`default_nettype none
module halfbridge_softstart_burst_ctrl_assertions #(
    parameter int P_BM_ENTRY_CYC = hb_ctrl_pkg::BM_ENTRY_CYC
) (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire hb_ctrl_pkg::sense_t    sense,
    input wire hb_ctrl_pkg::freq_cfg_t cfg,
    input wire hb_ctrl_pkg::cmd_t      cmd
);
    import hb_ctrl_pkg::*;
    // ----
    // Helpers
    // ----
    logic [17:0] ss0;
    int          low_cnt;
    assign ss0 = 18'h00004 * 18'(cfg.fmax - cfg.fmin) + 18'(cfg.fmin);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) low_cnt <= 0;
        else if (cmd.stage_run && !cmd.bm_clamp_en && !cmd.burst_active
                 && sense.burst_control_mv < BM_ENTRY_MV) low_cnt <= low_cnt + 1;
        else low_cnt <= 0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_idle_wait: assert property (
        !cmd.stage_run && !cmd.burst_active && !cmd.restart_req
        && !sense.bus_sense_input_ok |=> !cmd.stage_run) else $error("early run");
    a_ss_start: assert property (
        $rose(cmd.stage_run) && cmd.bm_clamp_en |-> cmd.freq_target
        == (ss0 > 18'h00514 ? SS_START_MAX : ss0[15:0])) else $error("start");
    a_fast_clamp: assert property (
        cmd.bm_clamp_en && cmd.freq_target > cfg.fmax
        |-> cmd.bm_clamp_mv == BM_ENTRY_MV) else $error("clamp");
    a_pause_hold: assert property (
        cmd.bm_clamp_en && sense.low_side_current_sense_above_ocp && !sense.burst_current_zero
        |=> cmd.freq_target >= $past(cmd.freq_target)) else $error("pause");
    a_hand_over: assert property (
        cmd.bm_clamp_en && cmd.bm_clamp_mv > BM_ENTRY_MV
        && sense.burst_current_zero |=> !cmd.bm_clamp_en && cmd.freq_target
        == 16'(sense.frequency_set_node_ua) * 16'h0002 / 16'h0005)
        else $error("handover");
    a_entry_time: assert property (
        low_cnt <= P_BM_ENTRY_CYC + 3) else $error("late entry");
    a_sleep_wake: assert property (
        !cmd.stage_run && cmd.burst_active && !cmd.restart_req
        && sense.burst_control_mv >= BM_MAX_MV |=> cmd.stage_run)
        else $error("wake");
    a_fault_stop: assert property (
        cmd.restart_req |=> cmd.restart_req && !cmd.stage_run)
        else $error("fault");
    a_dead_range: assert property (
        cmd.stage_run |-> cmd.dead_time inside {[4'h3:4'h7]})
        else $error("dead time");
endmodule
bind halfbridge_softstart_burst_ctrl
    halfbridge_softstart_burst_ctrl_assertions #(
        .P_BM_ENTRY_CYC(P_BM_ENTRY_CYC)) i_hb_assertions (
        .clk(clk), .rst_n(rst_n), .sense(sense), .cfg(cfg), .cmd(cmd));
`default_nettype wire

/* File: sim/halfbridge_softstart_burst_ctrl_bench.sv */
// Self-checking bench for the half-bridge sequencer
`timescale 1ns/1ps
`default_nettype none
module halfbridge_softstart_burst_ctrl_bench;
    import hb_ctrl_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        bus_ok = 1'b0;
    logic        bcz = 1'b0;
    logic        ocp = 1'b0;
    logic [11:0] mv = 12'h5DC;
    logic [11:0] ua = 12'h104;
    logic        hs, ls, neg;
    sense_t      sense;
    freq_cfg_t   cfg = '{16'h0064, 16'h0078, 16'h0073};
    cmd_t        cmd;
    logic [15:0] f;
    int          miscompares = 0;
    int          compares = 0;
    int          cyc = 0;
    int          i;
    always #50 clk = ~clk;
    always_comb sense = '{bus_ok, bcz, ocp, neg, hs, ls, mv, ua};
    // Short phase counts keep the run brief; phase one keeps its length
    halfbridge_softstart_burst_ctrl #(.P_SS2_CYC(256),
        .P_SS3_CYC(1500), .P_BM_ENTRY_CYC(100), .P_BURST_ON_CYC(200),
        .P_OVERCURRENT_LEVEL_ONE_CYC(100)) i_halfbridge_softstart_burst_ctrl (
        .clk(clk), .rst_n(rst_n), .sense(sense), .cfg(cfg), .cmd(cmd));
    hb_stage_model i_hb_stage_model (.clk(clk), .rst_n(rst_n),
        .run(cmd.stage_run), .hs(hs), .ls(ls), .neg(neg));
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic conclude;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_start;
        repeat (20) @(negedge clk);
        check(cmd.stage_run === 1'b0, "run before bus");
        bus_ok = 1'b1;
        @(negedge clk);
        check(cmd.freq_target === 16'h00B4, "ss0");
        ocp = 1'b1;
        f = cmd.freq_target;
        repeat (30) @(negedge clk);
        check(cmd.freq_target >= f, "no pause");
        ocp = 1'b0;
        // Paused cycles must not age phase one
        for (i = 0; i < 6400 && cmd.freq_target !== 16'h0098; i++)
            @(negedge clk);
        check(i > SS1_CYC - 8 && i < SS1_CYC + 8, "ss1 end");
        check(cmd.bm_clamp_mv === BM_ENTRY_MV, "ss1 clamp");
        for (i = 0; i < 400 && cmd.freq_target !== 16'h0078; i++)
            @(negedge clk);
        check(i < 400, "fmax");
        for (i = 0; i < 1600 && cmd.freq_target !== 16'h0064; i++)
            @(negedge clk);
        check(i < 1600 && cmd.bm_clamp_mv > BM_ENTRY_MV, "ss3");
        check(cmd.dead_time inside {[4'h3:4'h5]}, "dead time");
        bcz = 1'b1;
        @(negedge clk);
        check(!cmd.bm_clamp_en, "cco");
        check(cmd.freq_target === 16'h0068, "cco freq");
        bcz = 1'b0;
        $display("start done");
    endtask
    task automatic t_enter;
        mv = 12'h1F4;
        repeat (90) @(negedge clk);
        check(cmd.burst_active === 1'b0, "early entry");
        for (i = 0; i < 300 && cmd.stage_run !== 1'b0; i++) @(negedge clk);
        check(cmd.burst_active === 1'b1, "sleep");
        check(cmd.freq_target === 16'h007E, "sleep freq");
        $display("entry done");
    endtask
    task automatic t_wake(input int arm);
        mv = BM_WARN_MV;
        repeat (arm) @(negedge clk);
        mv = BM_MAX_MV;
        repeat (2) @(negedge clk);
        check(cmd.stage_run === 1'b1, "wake");
        check(cmd.burst_active === (arm > SLEEP_WIN_CYC), "fast");
        mv = 12'h5DC;
        $display("wake done");
    endtask
    task automatic t_burst(input logic off);
        t_wake(4100);
        for (i = 0; i < 200 && cmd.freq_target !== 16'h0073; i++)
            @(negedge clk);
        repeat (20) @(negedge clk);
        check(cmd.freq_target === 16'h0073, "power limit");
        bcz = off;
        for (i = 0; i < 400 && cmd.burst_active === 1'b1
             && cmd.stage_run === 1'b1; i++) @(negedge clk);
        check(cmd.stage_run !== off, "exit run");
        check(cmd.burst_active === off, "exit burst");
        bcz = 1'b0;
        $display("burst done");
    endtask
    task automatic t_fault;
        ocp = 1'b1;
        repeat (40) @(negedge clk);
        check(cmd.freq_target > 16'h0068, "fold");
        check(cmd.freq_target <= 16'h0078, "fold cap");
        for (i = 0; i < 400 && cmd.restart_req !== 1'b1; i++) @(negedge clk);
        check(cmd.restart_req && !cmd.stage_run, "no restart");
        $display("fault done");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        t_start();
        t_enter();
        t_wake(10);
        t_enter();
        t_burst(1'b1);
        t_burst(1'b0);
        t_fault();
        conclude();
    end
endmodule
`default_nettype wire
